/* File: logic/flash_cmd_cfg.svh */
// Functional notes
// - A 64-byte one-time field of 8 phrases, readable only by one-time read.
// - Clearing command complete launches one-time read; phrase lands in words 2-5.
// - One-time read accepts phrase index 0x0000-0x0007; otherwise access error.
// - Program flash reads return invalid data while one-time read runs.
// - One-time read needs index selector 001 at launch, else access error.
// - Read once, program and program once raise access error if mode forbids.
// - One-time read sets any-error on read errors, uncorrectable on hard ones.
// - Phrase program address low three bits not 000 gives access error.
// - Phrase program and one-time program need index selector 101 at launch.
// - Phrase program address outside valid flash gives access error.
// - Phrase program address bits 17:0 inside protected region give violation.
// - Phrase program writes four words, reads back to verify, then completes.
// - Verify sets any-error on errors, uncorrectable on non-correctable errors.
// - One-time program checks erased, programs, verifies, then sets complete.
// - Second programming of a one-time phrase is refused with access error.
// - One-time program accepts phrase index 0x0000-0x0007; otherwise access error.
// - Program flash reads return invalid data while one-time program runs.
// - Invalid command code sets access error and is not executed.
`ifndef FLASH_CMD_CFG_SVH
`define FLASH_CMD_CFG_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_STATUS 8'h00
`define OFS_INDEX 8'h04
`define OFS_PARAM 8'h08
`define OFS_MODE 8'h0C
`define OFS_PROT_LO 8'h10
`define OFS_PROT_HI 8'h14
`define OFS_RD_ADDR 8'h18
`define OFS_RD_DATA 8'h1C

// ****************************************
// Status fields
// ****************************************
`define BIT_CCF 7
`define BIT_ACC 5
`define BIT_FPV 4
`define BIT_MG1 1
`define BIT_MG0 0

// ****************************************
// Commands and parameters
// ****************************************
`define CMD_READ_ONCE 8'h04
`define CMD_PROG_PHRASE 8'h06
`define CMD_PROG_ONCE 8'h07
`define IX_READ_ONCE 3'h1
`define IX_PROGRAM 3'h5
`define ONCE_IDX_MAX 16'h0007
`define PARAM_WORDS 6
`define ONCE_PHRASES 8
`define MAIN_PHRASES 16
`define PF_TAG 17'h1FFFF
`define MODE_RST 2'h3
`define PROT_LO_RST 18'h3FFFF
`define PROT_HI_RST 18'h00000
`define INVALID_DATA 32'hDEADDEAD

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS 10
`define PROG_TIME_NS 1000
`define PROG_CYC (`PROG_TIME_NS / `CLK_PERIOD_NS)

`endif

/* File: logic/flash_cmd_pkg.sv */
package flash_cmd_pkg;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_s;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_CHECK = 5'b00010,
    ST_READ = 5'b00100,
    ST_PROG = 5'b01000,
    ST_VERIFY = 5'b10000
  } seq_state_e;

  typedef logic [63:0] phrase_t;

endpackage

/* File: logic/phrase_store.sv */
`timescale 1ns/10ps
module phrase_store #(
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_idx_i,
  input wire flash_cmd_pkg::phrase_t wr_data_i,
  input wire logic [AW-1:0] rd_idx_i,
  output flash_cmd_pkg::phrase_t rd_data_o,
  output logic rd_blank_o
);

  flash_cmd_pkg::phrase_t mem_ff [DEPTH];

  // Programming only clears bits; reset stands in for an erased array
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= '1;
      end
    end else if (wr_en_i) begin
      mem_ff[wr_idx_i] <= mem_ff[wr_idx_i] & wr_data_i;
    end
  end

  assign rd_data_o = mem_ff[rd_idx_i];
  assign rd_blank_o = &mem_ff[rd_idx_i];

endmodule

/* File: logic/flash_once_and_program_cmds.sv */
`timescale 1ns/10ps
`include "flash_cmd_cfg.svh"
module flash_once_and_program_cmds (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire flash_cmd_pkg::wb_req_s wb_req_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic read_err_i,
  input wire logic read_uncorr_err_i,
  output logic busy_o
);

  // ****************************************
  // Declarations
  // ****************************************
  flash_cmd_pkg::seq_state_e state_ff;
  flash_cmd_pkg::seq_state_e nxt_state;
  logic [15:0] param_ff [`PARAM_WORDS];
  logic [2:0] index_ff;
  logic command_complete_flag_ff;
  logic access_error_flag_ff;
  logic protection_violation_flag_ff;
  logic any_error_status_bit_ff;
  logic uncorrectable_error_status_bit_ff;
  logic [1:0] mode_ff;
  logic [17:0] prot_lo_ff;
  logic [17:0] prot_hi_ff;
  logic [23:0] rd_addr_ff;
  logic [15:0] cnt_ff;
  logic [2:0] ix_at_launch_ff;
  logic wb_hit;
  logic wr_stb;
  logic [31:0] wmask;
  logic launch;
  logic [7:0] cmd;
  logic [23:0] gaddr;
  logic idx_ok;
  logic addr_ok;
  logic prot_hit;
  logic chk_acc;
  logic chk_fpv;
  logic prog_wr;
  logic [31:0] rd_word;
  logic [31:0] nxt_dat;
  logic [3:0] main_rd_idx;
  flash_cmd_pkg::phrase_t param_phrase;
  flash_cmd_pkg::phrase_t once_rd;
  flash_cmd_pkg::phrase_t main_rd;
  logic once_blank;

  // ****************************************
  // Bus decode
  // ****************************************
  assign wb_hit = wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
  assign wr_stb = wb_hit && wb_req_i.we;
  assign wmask = {{8{wb_req_i.sel[3]}}, {8{wb_req_i.sel[2]}},
                  {8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};

  // Launch only from idle with no stale error flag pending
  assign launch = wr_stb && (wb_req_i.adr == `OFS_STATUS) && wb_req_i.sel[0]
                  && wb_req_i.dat[`BIT_CCF] && command_complete_flag_ff
                  && !access_error_flag_ff && !protection_violation_flag_ff
                  && (state_ff == flash_cmd_pkg::ST_IDLE);

  // ****************************************
  // Launch checks
  // ****************************************
  assign cmd = param_ff[0][15:8];
  assign gaddr = {param_ff[0][7:0], param_ff[1]};
  assign idx_ok = (param_ff[1] <= `ONCE_IDX_MAX);
  assign addr_ok = (gaddr[23:7] == `PF_TAG);
  assign prot_hit = (gaddr[17:0] >= prot_lo_ff) && (gaddr[17:0] <= prot_hi_ff);
  assign param_phrase = {param_ff[5], param_ff[4], param_ff[3], param_ff[2]};

  always_comb begin
    chk_acc = 1'b0;
    chk_fpv = 1'b0;
    case (cmd)
      `CMD_READ_ONCE: begin
        if (ix_at_launch_ff != `IX_READ_ONCE) chk_acc = 1'b1;
        if (!mode_ff[0]) chk_acc = 1'b1;
        if (!idx_ok) chk_acc = 1'b1;
      end
      `CMD_PROG_PHRASE: begin
        if (ix_at_launch_ff != `IX_PROGRAM) chk_acc = 1'b1;
        if (!mode_ff[1]) chk_acc = 1'b1;
        if (!addr_ok) chk_acc = 1'b1;
        if (gaddr[2:0] != 3'h0) chk_acc = 1'b1;
        chk_fpv = prot_hit;
      end
      `CMD_PROG_ONCE: begin
        if (ix_at_launch_ff != `IX_PROGRAM) chk_acc = 1'b1;
        if (!mode_ff[0]) chk_acc = 1'b1;
        if (!idx_ok) chk_acc = 1'b1;
        else if (!once_blank) chk_acc = 1'b1;
      end
      default: begin
        chk_acc = 1'b1;
      end
    endcase
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      flash_cmd_pkg::ST_IDLE: begin
        if (launch) nxt_state = flash_cmd_pkg::ST_CHECK;
      end
      flash_cmd_pkg::ST_CHECK: begin
        if (chk_acc || chk_fpv) nxt_state = flash_cmd_pkg::ST_IDLE;
        else if (cmd == `CMD_READ_ONCE) nxt_state = flash_cmd_pkg::ST_READ;
        else nxt_state = flash_cmd_pkg::ST_PROG;
      end
      flash_cmd_pkg::ST_READ: begin
        nxt_state = flash_cmd_pkg::ST_IDLE;
      end
      flash_cmd_pkg::ST_PROG: begin
        if (prog_wr) nxt_state = flash_cmd_pkg::ST_VERIFY;
      end
      flash_cmd_pkg::ST_VERIFY: begin
        nxt_state = flash_cmd_pkg::ST_IDLE;
      end
      default: begin
        nxt_state = flash_cmd_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= flash_cmd_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Program pulse timer
  assign prog_wr = (state_ff == flash_cmd_pkg::ST_PROG)
                   && (cnt_ff == 16'(`PROG_CYC - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= 16'h0000;
    end else if (state_ff == flash_cmd_pkg::ST_PROG) begin
      cnt_ff <= cnt_ff + 16'h0001;
    end else begin
      cnt_ff <= 16'h0000;
    end
  end

  // ****************************************
  // Arrays
  // ****************************************
  // One-time field, reached only by the sequencer
  phrase_store #(
    .DEPTH(`ONCE_PHRASES),
    .AW(3)
  ) u_once (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_en_i(prog_wr && (cmd == `CMD_PROG_ONCE)),
    .wr_idx_i(param_ff[1][2:0]),
    .wr_data_i(param_phrase),
    .rd_idx_i(param_ff[1][2:0]),
    .rd_data_o(once_rd),
    .rd_blank_o(once_blank)
  );

  assign main_rd_idx = command_complete_flag_ff ? rd_addr_ff[6:3] : gaddr[6:3];

  phrase_store #(
    .DEPTH(`MAIN_PHRASES),
    .AW(4)
  ) u_main (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_en_i(prog_wr && (cmd == `CMD_PROG_PHRASE)),
    .wr_idx_i(gaddr[6:3]),
    .wr_data_i(param_phrase),
    .rd_idx_i(main_rd_idx),
    .rd_data_o(main_rd),
    .rd_blank_o()
  );

  // ****************************************
  // Status flags
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      command_complete_flag_ff <= 1'b1;
    end else if (launch) begin
      command_complete_flag_ff <= 1'b0;
    end else if (state_ff == flash_cmd_pkg::ST_CHECK && (chk_acc || chk_fpv)) begin
      command_complete_flag_ff <= 1'b1;
    end else if (state_ff == flash_cmd_pkg::ST_READ
                 || state_ff == flash_cmd_pkg::ST_VERIFY) begin
      command_complete_flag_ff <= 1'b1;
    end
  end

  // Clear by writing one; a set in the same cycle wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      access_error_flag_ff <= 1'b0;
      protection_violation_flag_ff <= 1'b0;
    end else begin
      if (wr_stb && wb_req_i.adr == `OFS_STATUS && wb_req_i.sel[0]) begin
        if (wb_req_i.dat[`BIT_ACC]) access_error_flag_ff <= 1'b0;
        if (wb_req_i.dat[`BIT_FPV]) protection_violation_flag_ff <= 1'b0;
      end
      if (state_ff == flash_cmd_pkg::ST_CHECK) begin
        if (chk_acc) access_error_flag_ff <= 1'b1;
        if (chk_fpv) protection_violation_flag_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      any_error_status_bit_ff <= 1'b0;
      uncorrectable_error_status_bit_ff <= 1'b0;
    end else if (launch) begin
      any_error_status_bit_ff <= 1'b0;
      uncorrectable_error_status_bit_ff <= 1'b0;
    end else if (state_ff == flash_cmd_pkg::ST_READ) begin
      any_error_status_bit_ff <= read_err_i || read_uncorr_err_i;
      uncorrectable_error_status_bit_ff <= read_uncorr_err_i;
    end else if (state_ff == flash_cmd_pkg::ST_VERIFY) begin
      // Read-back mismatch counts as non-correctable
      if (cmd == `CMD_PROG_ONCE) begin
        any_error_status_bit_ff <= read_err_i || read_uncorr_err_i
                                   || (once_rd != param_phrase);
        uncorrectable_error_status_bit_ff <= read_uncorr_err_i
                                             || (once_rd != param_phrase);
      end else begin
        any_error_status_bit_ff <= read_err_i || read_uncorr_err_i
                                   || (main_rd != param_phrase);
        uncorrectable_error_status_bit_ff <= read_uncorr_err_i
                                             || (main_rd != param_phrase);
      end
    end
  end

  // ****************************************
  // Parameter words
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < `PARAM_WORDS; i++) begin
        param_ff[i] <= 16'h0000;
      end
    end else if (state_ff == flash_cmd_pkg::ST_READ) begin
      param_ff[2] <= once_rd[15:0];
      param_ff[3] <= once_rd[31:16];
      param_ff[4] <= once_rd[47:32];
      param_ff[5] <= once_rd[63:48];
    end else if (wr_stb && wb_req_i.adr == `OFS_PARAM && command_complete_flag_ff
                 && index_ff < 3'(`PARAM_WORDS)) begin
      param_ff[index_ff] <= (param_ff[index_ff] & ~wmask[15:0])
                            | (wb_req_i.dat[15:0] & wmask[15:0]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ix_at_launch_ff <= 3'h0;
    end else if (launch) begin
      ix_at_launch_ff <= index_ff;
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      index_ff <= 3'h0;
      mode_ff <= `MODE_RST;
      prot_lo_ff <= `PROT_LO_RST;
      prot_hi_ff <= `PROT_HI_RST;
      rd_addr_ff <= 24'h000000;
    end else if (wr_stb) begin
      case (wb_req_i.adr)
        `OFS_INDEX: if (wb_req_i.sel[0] && command_complete_flag_ff) begin
          index_ff <= wb_req_i.dat[2:0];
        end
        `OFS_MODE: if (wb_req_i.sel[0]) begin
          mode_ff <= wb_req_i.dat[1:0];
        end
        `OFS_PROT_LO: begin
          prot_lo_ff <= (prot_lo_ff & ~wmask[17:0]) | (wb_req_i.dat[17:0] & wmask[17:0]);
        end
        `OFS_PROT_HI: begin
          prot_hi_ff <= (prot_hi_ff & ~wmask[17:0]) | (wb_req_i.dat[17:0] & wmask[17:0]);
        end
        `OFS_RD_ADDR: begin
          rd_addr_ff <= (rd_addr_ff & ~wmask[23:0]) | (wb_req_i.dat[23:0] & wmask[23:0]);
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Read path and acknowledge
  // ****************************************
  // Array reads while a command runs give a fixed garbage word
  always_comb begin
    if (!command_complete_flag_ff) begin
      rd_word = `INVALID_DATA;
    end else if (rd_addr_ff[23:7] != `PF_TAG) begin
      rd_word = 32'h00000000;
    end else begin
      rd_word = rd_addr_ff[2] ? main_rd[63:32] : main_rd[31:0];
    end
  end

  always_comb begin
    nxt_dat = 32'h00000000;
    case (wb_req_i.adr)
      `OFS_STATUS: begin
        nxt_dat[`BIT_CCF] = command_complete_flag_ff;
        nxt_dat[`BIT_ACC] = access_error_flag_ff;
        nxt_dat[`BIT_FPV] = protection_violation_flag_ff;
        nxt_dat[`BIT_MG1] = any_error_status_bit_ff;
        nxt_dat[`BIT_MG0] = uncorrectable_error_status_bit_ff;
      end
      `OFS_INDEX: nxt_dat[2:0] = index_ff;
      `OFS_PARAM: if (index_ff < 3'(`PARAM_WORDS)) nxt_dat[15:0] = param_ff[index_ff];
      `OFS_MODE: nxt_dat[1:0] = mode_ff;
      `OFS_PROT_LO: nxt_dat[17:0] = prot_lo_ff;
      `OFS_PROT_HI: nxt_dat[17:0] = prot_hi_ff;
      `OFS_RD_ADDR: nxt_dat[23:0] = rd_addr_ff;
      `OFS_RD_DATA: nxt_dat = rd_word;
      default: nxt_dat = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_hit;
      if (wb_hit && !wb_req_i.we) wb_dat_o <= nxt_dat;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= (nxt_state != flash_cmd_pkg::ST_IDLE);
    end
  end

endmodule

/* File: sim/flash_cmd_chk.sv */
`timescale 1ns/10ps
`include "flash_cmd_cfg.svh"
module flash_cmd_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire flash_cmd_pkg::wb_req_s wb_req_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic read_err_i,
  input wire logic read_uncorr_err_i,
  input wire logic busy_o
);
  logic req_w;
  logic launch_w;
  logic rd_inv_w;
  logic unmap_w;
  logic [7:0] busy_cnt_ff;

  // ****************************************
  // Helper decode
  // ****************************************
  assign req_w = wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
  assign launch_w = req_w && wb_req_i.we && wb_req_i.adr == `OFS_STATUS && wb_req_i.sel[0]
    && wb_req_i.dat[`BIT_CCF];
  assign rd_inv_w = req_w && !wb_req_i.we && wb_req_i.adr == `OFS_RD_DATA && busy_o;
  assign unmap_w = req_w && !wb_req_i.we && wb_req_i.adr >= 8'h20;

  always_ff @(posedge clk_i) begin
    if (rst_i || !busy_o) begin
      busy_cnt_ff <= 8'h00;
    end else if (busy_cnt_ff != 8'hFF) begin
      busy_cnt_ff <= busy_cnt_ff + 8'h01;
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_next: assert property (req_w |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(req_w))
    else $error("ack without request");
  a_busy_cause: assert property ($rose(busy_o) |-> $past(launch_w) || $past(launch_w, 2))
    else $error("busy without launch");
  a_busy_bound: assert property (busy_cnt_ff < 8'h6E)
    else $error("command runs too long");
  a_invalid_read: assert property (rd_inv_w |=> !busy_o || wb_dat_o == `INVALID_DATA)
    else $error("array data visible while busy");
  a_dat_hold: assert property (!wb_ack_o |-> $stable(wb_dat_o))
    else $error("read data changed without ack");
  a_unmapped_zero: assert property (unmap_w |=> wb_dat_o == 32'h00000000)
    else $error("unmapped read not zero");

  c_launch: cover property (launch_w);
  c_done: cover property ($fell(busy_o));
  c_busy_read: cover property (rd_inv_w);
endmodule

bind flash_once_and_program_cmds flash_cmd_chk i_chk (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .wb_req_i(wb_req_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .read_err_i(read_err_i),
  .read_uncorr_err_i(read_uncorr_err_i),
  .busy_o(busy_o)
);

/* File: sim/testbench.sv */
`timescale 1ns/10ps
`include "flash_cmd_cfg.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  flash_cmd_pkg::wb_req_s wb_req_i = '0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic read_err_i = 1'b0;
  logic read_uncorr_err_i = 1'b0;
  logic busy_o;
  int miscompares = 0;
  int checks_done = 0;
  logic [15:0] lfsr_ff = 16'h002C;
  logic [31:0] rd_v;
  logic [15:0] dw [4];
  logic [15:0] pw [4];
  logic [2:0] px;
  logic [7:0] bc [7] = '{`CMD_READ_ONCE, `CMD_PROG_ONCE, `CMD_READ_ONCE, `CMD_PROG_PHRASE,
    `CMD_PROG_PHRASE, `CMD_PROG_PHRASE, 8'h05};
  logic [23:0] ba [7] = '{24'h000008, 24'h000008, 24'h000000, 24'hFFFF88, 24'hFFFF8A,
    24'hFEFF88, 24'h000000};
  logic [2:0] bx [7] = '{3'h1, 3'h5, 3'h5, 3'h1, 3'h5, 3'h5, 3'h5};

  always #5 clk_i = ~clk_i;

  flash_once_and_program_cmds i_dut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_req_i(wb_req_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .read_err_i(read_err_i),
    .read_uncorr_err_i(read_uncorr_err_i),
    .busy_o(busy_o)
  );

  // ****************************************
  // Bench tasks
  // ****************************************
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Status byte once a command has finished
  function automatic logic [7:0] exp_stat(input logic acc, input logic fpv, input logic mg1,
                                           input logic mg0);
    logic [7:0] s;
    s = 8'h00;
    s[`BIT_CCF] = 1'b1;
    s[`BIT_ACC] = acc;
    s[`BIT_FPV] = fpv;
    s[`BIT_MG1] = mg1;
    s[`BIT_MG0] = mg0;
    return s;
  endfunction

  task automatic rnd_words();
    for (int i = 0; i < 4; i++) begin
      lfsr_ff = lfsr_next(lfsr_ff);
      dw[i] = lfsr_ff;
    end
  endtask

  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge clk_i);
    wb_req_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      end_sim();
    end
    q = wb_dat_o;
    wb_req_i <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h00000000, rd_v);
  endtask

  // Loads parameters, launches, polls completion; status left in rd_v
  task automatic cmd(input logic [7:0] c, input logic [23:0] ad, input logic [2:0] ix,
                     input logic inv);
    int n;
    wr(`OFS_STATUS, 32'h00000030);
    for (int i = 0; i < 6; i++) begin
      wr(`OFS_INDEX, 32'(i));
      wr(`OFS_PARAM, {16'h0000, i == 0 ? {c, ad[23:16]} : i == 1 ? ad[15:0] : dw[i-2]});
    end
    wr(`OFS_INDEX, {29'h00000000, ix});
    wr(`OFS_STATUS, 32'h00000080);
    if (inv) begin
      rd(`OFS_RD_DATA);
      `CHK("busy read", `INVALID_DATA, rd_v)
      `CHK("busy flag", 1'b1, busy_o)
    end
    n = 0;
    do begin
      rd(`OFS_STATUS);
      n++;
    end while (rd_v[`BIT_CCF] !== 1'b1 && n < 200);
    if (n >= 200) begin
      miscompares++;
      end_sim();
    end
    `CHK("idle flag", 1'b0, busy_o)
  endtask

  task automatic chk_par();
    for (int i = 0; i < 4; i++) begin
      wr(`OFS_INDEX, 32'(i + 2));
      rd(`OFS_PARAM);
      `CHK("param word", {16'h0000, dw[i]}, rd_v)
    end
  endtask

  task automatic rd_arr(input logic [23:0] ad);
    wr(`OFS_RD_ADDR, {8'h00, ad});
    rd(`OFS_RD_DATA);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`OFS_STATUS);
    `CHK("reset status", 32'h00000080, rd_v)
    rd(`OFS_MODE);
    `CHK("reset mode", 32'h00000003, rd_v)
    rd(8'h40);
    `CHK("unmapped", 32'h00000000, rd_v)
    $display("test reset done");
    rnd_words();
    px = dw[0][2:0];
    dw = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
    cmd(`CMD_READ_ONCE, {21'h0, px}, `IX_READ_ONCE, 1'b0);
    `CHK("read once status", exp_stat(1'b0, 1'b0, 1'b0, 1'b0), rd_v[7:0])
    dw = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
    chk_par();
    rnd_words();
    pw = dw;
    cmd(`CMD_PROG_ONCE, {21'h0, px}, `IX_PROGRAM, 1'b1);
    `CHK("program once status", exp_stat(1'b0, 1'b0, 1'b0, 1'b0), rd_v[7:0])
    cmd(`CMD_PROG_ONCE, {21'h0, px}, `IX_PROGRAM, 1'b0);
    `CHK("second program", exp_stat(1'b1, 1'b0, 1'b0, 1'b0), rd_v[7:0])
    dw = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
    cmd(`CMD_READ_ONCE, {21'h0, px}, `IX_READ_ONCE, 1'b0);
    dw = pw;
    chk_par();
    $display("test once done");
    for (int i = 0; i < 7; i++) begin
      cmd(bc[i], ba[i], bx[i], 1'b0);
      `CHK("bad launch", exp_stat(1'b1, 1'b0, 1'b0, 1'b0), rd_v[7:0])
    end
    wr(`OFS_PROT_LO, 32'h0003FF90);
    wr(`OFS_PROT_HI, 32'h0003FF90);
    cmd(`CMD_PROG_PHRASE, 24'hFFFF90, `IX_PROGRAM, 1'b0);
    `CHK("protected", 8'h90, rd_v[7:0])
    rd_arr(24'hFFFF90);
    `CHK("untouched", 32'hFFFFFFFF, rd_v)
    rd_arr(24'h000000);
    `CHK("outside flash", 32'h00000000, rd_v)
    wr(`OFS_MODE, 32'h00000000);
    cmd(`CMD_READ_ONCE, 24'h000000, `IX_READ_ONCE, 1'b0);
    `CHK("mode once", 8'hA0, rd_v[7:0])
    wr(`OFS_MODE, 32'h00000001);
    cmd(`CMD_PROG_PHRASE, 24'hFFFF88, `IX_PROGRAM, 1'b0);
    `CHK("mode program", 8'hA0, rd_v[7:0])
    wr(`OFS_MODE, 32'h00000003);
    $display("test errors done");
    rnd_words();
    cmd(`CMD_PROG_PHRASE, 24'hFFFF88, `IX_PROGRAM, 1'b1);
    `CHK("phrase status", 8'h80, rd_v[7:0])
    rd_arr(24'hFFFF88);
    `CHK("phrase low", {dw[1], dw[0]}, rd_v)
    rd_arr(24'hFFFF8C);
    `CHK("phrase high", {dw[3], dw[2]}, rd_v)
    read_err_i <= 1'b1;
    cmd(`CMD_READ_ONCE, {21'h0, px}, `IX_READ_ONCE, 1'b0);
    `CHK("read err", 8'h82, rd_v[7:0])
    read_uncorr_err_i <= 1'b1;
    cmd(`CMD_READ_ONCE, {21'h0, px}, `IX_READ_ONCE, 1'b0);
    `CHK("read uncorr", 8'h83, rd_v[7:0])
    read_uncorr_err_i <= 1'b0;
    cmd(`CMD_PROG_PHRASE, 24'hFFFF98, `IX_PROGRAM, 1'b1);
    `CHK("verify err", 8'h82, rd_v[7:0])
    read_err_i <= 1'b0;
    cmd(`CMD_READ_ONCE, {21'h0, px}, `IX_READ_ONCE, 1'b0);
    `CHK("err cleared", 8'h80, rd_v[7:0])
    $display("test program done");
    end_sim();
  end
endmodule
